// File: design/pes_regs.sv
// Purpose: per-phase status, mask and measurement register bank
// Assumes: serial port logic presents decoded byte-address requests
// Notes: reads answer one cycle after the request
//
// Contract
// - mask bit 0 routes phase overcurrent events to the shared flag.
// - mask bit 1 routes phase overvoltage events to the shared flag.
// - mask bit 2 routes phase undervoltage events to the shared flag.
// - mask bit 3 routes missing zero crossing events to the shared flag.
// - mask bit 4 routes real power direction changes to the shared flag.
// - mask bit 6 shows energy direction, zero positive, one negative.
// - overflow bit 4 sets when the apparent energy accumulator wraps.
// - overflow bit 1 sets when the reverse real accumulator wraps.
// - overflow bit 0 sets when the forward real accumulator wraps.
// - overflow flags stay set until host clears; never an error.
// - positive active power added each DSP cycle to forward accumulator.
// - negative active power magnitude added each DSP cycle to reverse accumulator.
// - power factor is signed 16 bits, lsb 2^-14, negative is reversed.
// - rms voltage holds latest DSP cycle value, lsb full scale/2^24.
// - rms current holds latest DSP cycle value, lsb full scale/2^24.
// - line frequency is reported with lsb of one millihertz.
// - phase condition flags are sticky, cleared only by host.
// - apparent power added each DSP cycle to apparent accumulator.

`timescale 1ns/1ps
`default_nettype none

module pes_regs
  import pes_pkg::*;
#(
  parameter int NPH = PES_NPH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_dsp_tick,
  input wire pes_phase_in_s i_phase [NPH],
  input wire logic [15:0] i_line_freq,
  input wire pes_reg_req_s i_req,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [PES_NCOND-1:0] o_route_set
);

  // ****************************************
  // address decode helper
  // ****************************************
  function automatic logic hit(input pes_addr_t a, input pes_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************
  // per-phase storage
  // ****************************************
  logic [4:0] mask_q [NPH];
  logic [4:0] mask_d [NPH];
  logic dir_q [NPH];
  logic dir_seen_q [NPH];
  logic [15:0] pf_q [NPH];
  logic [31:0] vrms_q [NPH];
  logic [31:0] irms_q [NPH];
  logic [15:0] freq_q;

  logic [31:0] epos [NPH];
  logic [31:0] eneg [NPH];
  logic [31:0] eapp [NPH];
  logic wrap_pos [NPH];
  logic wrap_neg [NPH];
  logic wrap_app [NPH];
  logic [7:0] flags [NPH];
  logic [7:0] ovfl [NPH];

  logic [PES_NCOND-1:0] route_ph [NPH];
  logic [PES_NCOND-1:0] route_d;
  logic [31:0] rd_ph [NPH];
  logic [31:0] rd_any;
  logic [31:0] rd_freq;

  // ****************************************
  // one slice per phase
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NPH; p++) begin : g_ph
      logic neg_now;
      logic pos_now;
      logic dir_change;
      logic wr_flags;
      logic wr_mask;
      logic wr_ovfl;
      logic [PES_NCOND-1:0] events;
      logic [7:0] flag_set;
      logic [7:0] ovfl_set;
      logic [31:0] mag_neg;

      // sign of active power; zero counts as forward flow
      assign neg_now = i_phase[p].act[31];
      assign pos_now = ~neg_now & (i_phase[p].act != 32'sh0);
      // two's complement magnitude; most negative code maps to 2^31
      assign mag_neg = 32'h0000_0000 - i_phase[p].act;

      // direction change needs a previous sample to compare against
      assign dir_change = i_dsp_tick & dir_seen_q[p] & (neg_now != dir_q[p]);

      // condition event bits in mask bit order
      assign events[PES_BIT_OC] = i_phase[p].cond[PES_BIT_OC];
      assign events[PES_BIT_OV] = i_phase[p].cond[PES_BIT_OV];
      assign events[PES_BIT_UV] = i_phase[p].cond[PES_BIT_UV];
      assign events[PES_BIT_MISS_CROSS] = i_phase[p].cond[PES_BIT_MISS_CROSS];
      assign events[PES_BIT_DIR_CHANGE] = dir_change;

      // masked routing toward the shared flag register
      assign route_ph[p] = events & mask_q[p];

      // write strobes for the writable registers
      assign wr_flags = i_req.wr & hit(i_req.addr, PES_OFS_FLAGS[p]);
      assign wr_mask = i_req.wr & hit(i_req.addr, PES_OFS_MASK[p]);
      assign wr_ovfl = i_req.wr & hit(i_req.addr, PES_OFS_OVFL[p]);

      // only the route enables are writable; direction is status
      assign mask_d[p] = wr_mask ? i_req.wdata[4:0] : mask_q[p];

      assign flag_set = {3'b000, events};

      // wrap pulses placed at their flag positions
      assign ovfl_set = (8'(wrap_app[p]) << PES_BIT_APP_WRAP)
                      | (8'(wrap_neg[p]) << PES_BIT_REV_WRAP)
                      | (8'(wrap_pos[p]) << PES_BIT_FWD_WRAP);

      // sticky condition flags, host clears by writing zero
      pes_sticky #(
        .IMPL(PES_IMPL_FLAGS)
      ) u_flags (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(flag_set),
        .i_wr(wr_flags),
        .i_wdata(i_req.wdata),
        .o_flags(flags[p])
      );

      // sticky wrap flags; hardware never clears them
      pes_sticky #(
        .IMPL(PES_IMPL_OVFL)
      ) u_ovfl (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(ovfl_set),
        .i_wr(wr_ovfl),
        .i_wdata(i_req.wdata),
        .o_flags(ovfl[p])
      );

      // forward real energy, only for positive power
      pes_energy_acc #(
        .W(32)
      ) u_epos (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_en(i_dsp_tick & pos_now),
        .i_add(i_phase[p].act),
        .o_acc(epos[p]),
        .o_wrap(wrap_pos[p])
      );

      // reverse real energy, magnitude of negative power
      pes_energy_acc #(
        .W(32)
      ) u_eneg (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_en(i_dsp_tick & neg_now),
        .i_add(mag_neg),
        .o_acc(eneg[p]),
        .o_wrap(wrap_neg[p])
      );

      // apparent energy, every dsp cycle
      pes_energy_acc #(
        .W(32)
      ) u_eapp (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_en(i_dsp_tick),
        .i_add(i_phase[p].app),
        .o_acc(eapp[p]),
        .o_wrap(wrap_app[p])
      );

      // mask and direction state
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          mask_q[p] <= PES_RST_MASK;
          dir_q[p] <= 1'b0;
          dir_seen_q[p] <= 1'b0;
        end else begin
          mask_q[p] <= mask_d[p];
          if (i_dsp_tick) begin
            dir_q[p] <= neg_now;
            dir_seen_q[p] <= 1'b1;
          end
        end
      end

      // measurement snapshots, refreshed each dsp cycle
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          pf_q[p] <= PES_RST_PF;
          vrms_q[p] <= PES_RST_WORD;
          irms_q[p] <= PES_RST_WORD;
        end else if (i_dsp_tick) begin
          pf_q[p] <= i_phase[p].pf;
          vrms_q[p] <= i_phase[p].vrms;
          irms_q[p] <= i_phase[p].irms;
        end
      end

      // read selection for this phase; zero when nothing matches
      assign rd_ph[p] =
        hit(i_req.addr, PES_OFS_FLAGS[p]) ? {24'h0, flags[p]} :
        hit(i_req.addr, PES_OFS_MASK[p]) ?
          {24'h0, 1'b0, dir_q[p], 1'b0, mask_q[p]} :
        hit(i_req.addr, PES_OFS_OVFL[p]) ? {24'h0, ovfl[p]} :
        hit(i_req.addr, PES_OFS_PF[p]) ? {16'h0, pf_q[p]} :
        hit(i_req.addr, PES_OFS_VRMS[p]) ? vrms_q[p] :
        hit(i_req.addr, PES_OFS_IRMS[p]) ? irms_q[p] :
        hit(i_req.addr, PES_OFS_EPOS[p]) ? epos[p] :
        hit(i_req.addr, PES_OFS_ENEG[p]) ? eneg[p] :
        hit(i_req.addr, PES_OFS_EAPP[p]) ? eapp[p] :
        32'h0000_0000;
    end
  endgenerate

  // ****************************************
  // line frequency snapshot
  // ****************************************
  // one count per millihertz, taken as delivered by the dsp
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      freq_q <= PES_RST_PF;
    end else if (i_dsp_tick) begin
      freq_q <= i_line_freq;
    end
  end

  assign rd_freq = hit(i_req.addr, PES_OFS_FREQ) ? {16'h0, freq_q} : 32'h0000_0000;

  // ****************************************
  // merge phases
  // ****************************************
  // offsets never overlap, so an or-merge is a clean mux
  always_comb begin
    rd_any = rd_freq;
    route_d = '0;
    for (int k = 0; k < NPH; k++) begin
      rd_any = rd_any | rd_ph[k];
      route_d = route_d | route_ph[k];
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // unmapped reads still answer, with zero data
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= PES_RST_WORD;
      o_reg_rvalid <= 1'b0;
      o_route_set <= '0;
    end else begin
      o_reg_rvalid <= i_req.rd;
      if (i_req.rd) begin
        o_reg_rdata <= rd_any;
      end
      o_route_set <= route_d;
    end
  end

endmodule

`default_nettype wire

// File: design/pes_pkg.sv
// Purpose: shared constants and carriers for the phase energy status bank
// Assumes: one 20 MHz clock, DSP results arrive on the same clock
// Notes: offsets are byte addresses of the device register space

package pes_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int PES_NPH = 3;
  localparam int PES_AW = 10;
  typedef logic [PES_AW-1:0] pes_addr_t;

  // ****************************************
  // register offsets, index 0/1/2 = phase a/b/c
  // ****************************************
  localparam pes_addr_t PES_OFS_FLAGS [PES_NPH] = '{10'h144, 10'h230, 10'h31c};
  localparam pes_addr_t PES_OFS_MASK [PES_NPH] = '{10'h145, 10'h231, 10'h31d};
  localparam pes_addr_t PES_OFS_OVFL [PES_NPH] = '{10'h146, 10'h232, 10'h31e};
  localparam pes_addr_t PES_OFS_PF [PES_NPH] = '{10'h1c6, 10'h2b2, 10'h39e};
  localparam pes_addr_t PES_OFS_VRMS [PES_NPH] = '{10'h1c8, 10'h2b4, 10'h3a0};
  localparam pes_addr_t PES_OFS_IRMS [PES_NPH] = '{10'h1cc, 10'h2b8, 10'h3a4};
  localparam pes_addr_t PES_OFS_EPOS [PES_NPH] = '{10'h1e8, 10'h2d4, 10'h3c0};
  localparam pes_addr_t PES_OFS_ENEG [PES_NPH] = '{10'h1ec, 10'h2d8, 10'h3c4};
  localparam pes_addr_t PES_OFS_EAPP [PES_NPH] = '{10'h1f8, 10'h2e4, 10'h3d0};
  localparam pes_addr_t PES_OFS_FREQ = 10'h3fc;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PES_BIT_OC = 0;
  localparam int PES_BIT_OV = 1;
  localparam int PES_BIT_UV = 2;
  localparam int PES_BIT_MISS_CROSS = 3;
  localparam int PES_BIT_DIR_CHANGE = 4;
  localparam int PES_BIT_DIR = 6;
  localparam int PES_BIT_FWD_WRAP = 0;
  localparam int PES_BIT_REV_WRAP = 1;
  localparam int PES_BIT_APP_WRAP = 4;
  localparam int PES_NCOND = 5;

  // implemented bits; everything else reads zero
  localparam logic [7:0] PES_IMPL_FLAGS = 8'h1f;
  localparam logic [7:0] PES_IMPL_OVFL = 8'h13;
  localparam logic [4:0] PES_RST_MASK = 5'h00;
  localparam logic [7:0] PES_RST_FLAGS = 8'h00;
  localparam logic [15:0] PES_RST_PF = 16'h0000;
  localparam logic [31:0] PES_RST_WORD = 32'h0000_0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic signed [31:0] act;   // active power, signed
    logic [31:0] app;          // apparent power
    logic signed [15:0] pf;    // lsb = 2^-14
    logic [31:0] vrms;         // lsb = full scale / 2^24
    logic [31:0] irms;         // lsb = full scale / 2^24
    logic [3:0] cond;          // missing crossing, low volt, high volt, high current pulses
  } pes_phase_in_s;

  typedef struct packed {
    logic wr;
    logic rd;
    pes_addr_t addr;
    logic [7:0] wdata;
  } pes_reg_req_s;

endpackage

// File: design/pes_sticky.sv
// Purpose: byte of sticky flags, set by hardware, cleared by writing zero
// Assumes: set pulses and writes on the same clock
// Notes: a set in the clearing cycle survives

`timescale 1ns/1ps
`default_nettype none

module pes_sticky
  import pes_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hff
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_set,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_flags
);
  logic [7:0] clr;
  logic [7:0] flags_d;

  // zero written clears, one written keeps; set beats clear
  assign clr = i_wr ? ~i_wdata : 8'h00;
  assign flags_d = ((o_flags & ~clr) | i_set) & IMPL;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_flags <= PES_RST_FLAGS;
    end else begin
      o_flags <= flags_d;
    end
  end

endmodule

`default_nettype wire

// File: design/pes_energy_acc.sv
// Purpose: 32-bit wrapping energy accumulator with wrap pulse
// Assumes: i_en is one cycle per DSP cycle at most
// Notes: the wrap pulse is registered beside the sum

`timescale 1ns/1ps
`default_nettype none

module pes_energy_acc
  import pes_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic [W-1:0] i_add,
  output logic [W-1:0] o_acc,
  output logic o_wrap
);
  logic [W:0] sum;

  // carry out of the top bit is the wrap
  assign sum = {1'b0, o_acc} + {1'b0, i_add};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_acc <= W'(PES_RST_WORD);
      o_wrap <= 1'b0;
    end else begin
      o_wrap <= i_en & sum[W];
      if (i_en) begin
        o_acc <= sum[W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/pes_host.sv
// Purpose: host master model for the register port
// Assumes: requests move at the falling edge
// Notes: one byte-address access per call
`timescale 1ns/1ps
`default_nettype none
module pes_host
  import pes_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output var pes_reg_req_s o_req
);
  // ****************
  // accesses
  // ****************
  initial o_req = '0;
  // released fields are inverted so stale values never look valid
  task automatic wr(input pes_addr_t a, input logic [7:0] v);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask
  // zero clears a sticky bit, one keeps it
  task automatic clr(input pes_addr_t a, input logic [7:0] keep);
    wr(a, keep);
  endtask
  // rvalid stands one cycle, so it is taken here
  task automatic rd(input pes_addr_t a, output logic [31:0] v, output logic ok);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    ok = (i_rvalid === 1'b1);
    v = i_rdata;
  endtask
  // usage between two readings across one wrap
  function automatic logic [32:0] usage(input logic [31:0] a, input logic [31:0] b, input logic w);
    return {1'b0, b} - {1'b0, a} + (w ? 33'h1_0000_0000 : 33'h0);
  endfunction
endmodule
`default_nettype wire

// File: tb/pes_regs_props.sv
// Purpose: port checks on the phase status bank
// Assumes: mask writes follow the register port timing
// Notes: the mask copy keeps only the writable low bits
`timescale 1ns/1ps
`default_nettype none
module pes_regs_props
  import pes_pkg::*;
#(
  parameter int NPH = PES_NPH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_dsp_tick,
  input wire pes_phase_in_s i_phase [NPH],
  input wire pes_reg_req_s i_req,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [PES_NCOND-1:0] o_route_set
);
  // ****************
  // mask copy and routed events
  // ****************
  logic [4:0] mk_q [NPH];
  logic [3:0] ev;
  logic dch_en;
  always_ff @(posedge i_clk_sys) begin
    for (int p = 0; p < NPH; p++) begin
      if (i_rst) begin
        mk_q[p] <= 5'h00;
      end else if (i_req.wr && i_req.addr == PES_OFS_MASK[p]) begin
        mk_q[p] <= i_req.wdata[4:0];
      end
    end
  end
  // rms copies follow the tick, so reads are judged from the ports alone
  logic [31:0] vr_q [NPH];
  logic [31:0] ir_q [NPH];
  logic [31:0] meas_exp;
  logic meas_hit;
  always_ff @(posedge i_clk_sys) begin
    for (int p = 0; p < NPH; p++) begin
      if (i_rst) begin
        vr_q[p] <= 32'h0;
        ir_q[p] <= 32'h0;
      end else if (i_dsp_tick) begin
        vr_q[p] <= i_phase[p].vrms;
        ir_q[p] <= i_phase[p].irms;
      end
    end
  end
  // expected answer of an rms read; a tick in the read cycle is not yet seen
  always_comb begin
    meas_hit = 1'b0;
    meas_exp = 32'h0;
    for (int p = 0; p < NPH; p++) begin
      if (i_req.addr == PES_OFS_VRMS[p]) begin
        meas_hit = i_req.rd;
        meas_exp = vr_q[p];
      end
      if (i_req.addr == PES_OFS_IRMS[p]) begin
        meas_hit = i_req.rd;
        meas_exp = ir_q[p];
      end
    end
  end
  // or over phases; an unmasked phase never routes
  always_comb begin
    ev = 4'h0;
    dch_en = 1'b0;
    for (int p = 0; p < NPH; p++) begin
      ev = ev | (i_phase[p].cond & mk_q[p][3:0]);
      dch_en = dch_en | mk_q[p][4];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_oc; o_route_set[0] == $past(ev[0]); endproperty
  property p_ov; o_route_set[1] == $past(ev[1]); endproperty
  property p_uv; o_route_set[2] == $past(ev[2]); endproperty
  property p_miss_cross; o_route_set[3] == $past(ev[3]); endproperty
  property p_dir_change; o_route_set[4] |-> $past(i_dsp_tick && dch_en); endproperty
  property p_meas; meas_hit |=> o_reg_rdata == $past(meas_exp); endproperty
  property p_rst; $fell(i_rst) |-> (o_route_set == 5'h00 && !o_reg_rvalid && o_reg_rdata == 32'h0); endproperty
  property p_rsp; o_reg_rvalid == $past(i_req.rd); endproperty
  property p_hold; !i_req.rd |=> $stable(o_reg_rdata); endproperty
  a_oc: assert property (p_oc) else $error("overcurrent route wrong");
  a_ov: assert property (p_ov) else $error("overvoltage route wrong");
  a_uv: assert property (p_uv) else $error("undervoltage route wrong");
  a_miss_cross: assert property (p_miss_cross) else $error("missing crossing route wrong");
  a_dir_change: assert property (p_dir_change) else $error("direction route without tick");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_rsp: assert property (p_rsp) else $error("read answer timing wrong");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_meas: assert property (p_meas) else $error("rms reading not the latest snapshot");
  c_read: cover property (o_reg_rvalid);
  c_oc: cover property (o_route_set[0]);
  c_dch: cover property (o_route_set[4]);
endmodule
bind pes_regs pes_regs_props #(.NPH(NPH)) i_pes_regs_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_dsp_tick(i_dsp_tick), .i_phase(i_phase), .i_req(i_req), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_route_set(o_route_set));
`default_nettype wire

// File: tb/pes_regs_bench.sv
// Purpose: self-checking bench for the phase status bank
// Assumes: 20 MHz clock, inputs move at the falling edge
// Notes: one phase is stimulated at a time, the others idle
`timescale 1ns/1ps
`default_nettype none
module pes_regs_bench
  import pes_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic [15:0] freq = 16'hc350;
  pes_phase_in_s ph [PES_NPH] = '{default: '0};
  pes_reg_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic [4:0] route;
  logic [31:0] d;
  logic ok;
  logic [31:0] ep [PES_NPH] = '{default: 32'h0};
  logic [31:0] en [PES_NPH] = '{default: 32'h0};
  logic [31:0] ea [PES_NPH] = '{default: 32'h0};
  int err_total = 0;
  int tests_run = 0;
  pes_regs i_pes_regs (.i_clk_sys(clk), .i_rst(rst), .i_dsp_tick(tick), .i_phase(ph), .i_line_freq(freq),
    .i_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_route_set(route));
  pes_host i_pes_host (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  initial begin
    forever #25 clk = ~clk;
  end
  // ****************
  // helpers
  // ****************
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input pes_addr_t a, input logic [31:0] exp);
    i_pes_host.rd(a, d, ok);
    cmp({32'h0, ok}, 33'h1);
    cmp({1'b0, d}, {1'b0, exp});
  endtask
  // expected sums kept here follow the accumulate rules
  task automatic dsp(input int p, input logic signed [31:0] act, input logic [31:0] app);
    @(negedge clk);
    ph[p].act = act;
    ph[p].app = app;
    ph[p].pf = act[15:0];
    ph[p].vrms = app + 32'h1;
    ph[p].irms = ~app;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    if (act > 0) ep[p] += act;
    if (act < 0) en[p] += -act;
    ea[p] += app;
  endtask
  task automatic pulse(input int p, input logic [3:0] c);
    @(negedge clk);
    ph[p].cond = c;
    @(negedge clk);
    ph[p].cond = 4'h0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    for (int p = 0; p < PES_NPH; p++) begin
      rdc(PES_OFS_MASK[p], 32'h0);
      rdc(PES_OFS_OVFL[p], 32'h0);
      rdc(PES_OFS_FLAGS[p], 32'h0);
      i_pes_host.wr(PES_OFS_MASK[p], 8'hff);
      rdc(PES_OFS_MASK[p], 32'h1f);
    end
    rdc(10'h000, 32'h0);
  endtask
  // all four events fire, only the masked one may route
  task automatic t_route();
    for (int p = 0; p < PES_NPH; p++) begin
      for (int k = 0; k < 4; k++) begin
        i_pes_host.wr(PES_OFS_MASK[p], 8'(1 << k));
        pulse(p, 4'hf);
        cmp(33'(route[3:0]), 33'(1 << k));
      end
      rdc(PES_OFS_FLAGS[p], 32'h0f);
      i_pes_host.clr(PES_OFS_FLAGS[p], 8'hfe);
      rdc(PES_OFS_FLAGS[p], 32'h0e);
      i_pes_host.clr(PES_OFS_FLAGS[p], 8'h00);
      rdc(PES_OFS_FLAGS[p], 32'h0);
    end
  endtask
  // wraps the forward and apparent accumulators, then reverses the flow and wraps the reverse one
  task automatic t_energy(input int p);
    i_pes_host.wr(PES_OFS_MASK[p], 8'h10);
    dsp(p, 32'sd7, 32'h8000_0000);
    rdc(PES_OFS_PF[p], 32'h7);
    rdc(PES_OFS_VRMS[p], 32'h8000_0001);
    rdc(PES_OFS_IRMS[p], 32'h7fff_ffff);
    dsp(p, 32'sh7fff_ffff, 32'h8000_0000);
    dsp(p, 32'sh7fff_ffff, 32'h0);
    rdc(PES_OFS_EPOS[p], ep[p]);
    cmp(i_pes_host.usage(32'h7, d, 1'b1), 33'h0_ffff_fffe);
    rdc(PES_OFS_EAPP[p], ea[p]);
    rdc(PES_OFS_OVFL[p], 32'h11);
    i_pes_host.clr(PES_OFS_OVFL[p], 8'hff);
    rdc(PES_OFS_OVFL[p], 32'h11);
    dsp(p, -32'sd5, 32'h0);
    cmp(33'(route[4]), 33'h1);
    rdc(PES_OFS_MASK[p], 32'h50);
    rdc(PES_OFS_FLAGS[p], 32'h10);
    rdc(PES_OFS_PF[p], 32'h0000_fffb);
    dsp(p, -32'sh7fff_ffff, 32'h0);
    cmp(33'(route[4]), 33'h0);
    dsp(p, -32'sh7fff_ffff, 32'h0);
    rdc(PES_OFS_ENEG[p], en[p]);
    rdc(PES_OFS_OVFL[p], 32'h13);
    i_pes_host.clr(PES_OFS_OVFL[p], 8'h00);
    rdc(PES_OFS_OVFL[p], 32'h0);
    // park this phase so the next one runs alone
    i_pes_host.wr(PES_OFS_MASK[p], 8'h00);
    ph[p] = '0;
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_route();
    for (int p = 0; p < PES_NPH; p++) begin
      t_energy(p);
    end
    rdc(PES_OFS_FREQ, 32'h0000_c350);
    summarize();
  end
  // run needs about 260 cycles; the limit of 20000 cycles leaves wide room
  initial begin
    #(50 * 20000);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
